/* src/phy_basic_control_regs.sv */
`timescale 1ns/1ps
module phy_basic_control_regs
   import phy_regs_pkg::*;
#(
   parameter logic [15:0] SOFT_RESET_EXEMPT = EXEMPT_NONE
) (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_mgmt_req,
   input wire logic i_mgmt_write,
   input wire logic [4:0] i_mgmt_index,
   input wire logic [15:0] i_mgmt_wdata,
   input wire logic i_aneg_done,
   input wire logic i_aneg_speed_100,
   input wire logic i_aneg_full_duplex,
   output logic o_mgmt_ack,
   output logic o_index_valid,
   output logic [15:0] o_mgmt_rdata,
   output logic o_soft_reset,
   output logic o_loopback,
   output logic o_speed_100,
   output logic o_full_duplex,
   output logic o_aneg_enable,
   output logic o_aneg_restart,
   output logic o_power_down,
   output logic o_col_test,
   output logic o_aneg_complete
);

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic index_mapped(input logic [4:0] idx);
      case (idx)
         IDX_BASIC_CTRL, IDX_BASIC_STAT, IDX_ID_HI, IDX_ID_LO,
         IDX_ANEG_ADV, IDX_ANEG_PARTNER, IDX_ANEG_EXP, IDX_MODE_CTRL,
         IDX_SPECIAL_MODES, IDX_SPECIAL_IND, IDX_INT_SOURCE,
         IDX_INT_MASK, IDX_SPECIAL_CTRL: index_mapped = 1'b1; // RQ2
         default: index_mapped = 1'b0;
      endcase
   endfunction

   // Reset image; speed and duplex follow the negotiation outcome
   function automatic logic [15:0] ctrl_reset_image(
      input logic spd, input logic dup);
      logic [15:0] v;
      v = CTRL_RESET_VAL;
      v[CTRL_SPEED] = spd; // RQ13
      v[CTRL_DUPLEX] = dup; // RQ13
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // State

   logic [15:0] ctrl;
   logic [15:0] next_ctrl;
   logic restart;
   logic next_restart;
   logic aneg_done;
   logic next_aneg_done;
   logic neg_speed;
   logic next_neg_speed;
   logic neg_duplex;
   logic next_neg_duplex;
   logic eff_speed;
   logic next_eff_speed;
   logic eff_duplex;
   logic next_eff_duplex;
   logic ack;
   logic next_ack;
   logic idx_ok;
   logic next_idx_ok;
   logic [15:0] rdata;
   logic [15:0] next_rdata;
   logic srst_busy;
   logic srst_start;
   logic ctrl_wr;
   logic aneg_set;
   logic aneg_clr;
   logic [15:0] ctrl_view;
   logic [15:0] rst_image;

   phy_soft_reset_seq #(
      .CYCLES(SRST_CYCLES)
   ) u_srst (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_start(srst_start),
      .o_busy(srst_busy)
   );

   ////////////////////////////////////////////////////////////////////////
   // Indexed access, no memory mapping

   always_comb begin
      // Writes during a soft reset are dropped
      ctrl_wr = i_mgmt_req && i_mgmt_write && !srst_busy &&
         (i_mgmt_index == IDX_BASIC_CTRL); // RQ1
      srst_start = ctrl_wr && i_mgmt_wdata[CTRL_RESET]; // RQ4
      ctrl_view = ctrl;
      ctrl_view[CTRL_RESET] = srst_busy; // RQ4
      ctrl_view[CTRL_RESTART] = restart; // RQ10
      next_ack = i_mgmt_req;
      next_idx_ok = i_mgmt_req ? index_mapped(i_mgmt_index) : idx_ok;
      next_rdata = rdata;
      if (i_mgmt_req && !i_mgmt_write) begin
         case (i_mgmt_index)
            IDX_BASIC_CTRL: next_rdata = ctrl_view;
            IDX_BASIC_STAT: begin
               next_rdata = STAT_FIXED;
               next_rdata[STAT_ANEG_DONE] = aneg_done; // RQ14
            end
            default: next_rdata = '0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Basic control register

   always_comb begin
      rst_image = ctrl_reset_image(neg_speed, neg_duplex);
      next_ctrl = ctrl;
      next_restart = 1'b0; // RQ10
      // A reset write stores nothing, so exempt fields survive it
      if (ctrl_wr && !srst_start) begin // RQ3
         next_ctrl = i_mgmt_wdata & CTRL_STORE_MASK; // RQ15
         next_restart = i_mgmt_wdata[CTRL_RESTART]; // RQ10
      end
      if (srst_busy) begin
         next_ctrl = (ctrl & SOFT_RESET_EXEMPT) |
            (rst_image & ~SOFT_RESET_EXEMPT); // RQ3
         next_restart = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Negotiation status and effective mode

   always_comb begin
      aneg_set = i_aneg_done && ctrl[CTRL_ANEG_EN] &&
         !ctrl[CTRL_POWER_DOWN] && !srst_busy; // RQ9
      aneg_clr = restart || srst_busy || !ctrl[CTRL_ANEG_EN] ||
         ctrl[CTRL_POWER_DOWN]; // RQ9
      next_aneg_done = aneg_done;
      if (aneg_clr) begin
         next_aneg_done = 1'b0;
      end
      if (aneg_set) begin
         next_aneg_done = 1'b1; // RQ14
      end
      next_neg_speed = neg_speed;
      next_neg_duplex = neg_duplex;
      if (aneg_set) begin
         next_neg_speed = i_aneg_speed_100;
         next_neg_duplex = i_aneg_full_duplex;
      end
      // Manual bits only count with negotiation off
      if (ctrl[CTRL_ANEG_EN]) begin
         next_eff_speed = neg_speed; // RQ7
         next_eff_duplex = neg_duplex; // RQ11
      end else begin
         next_eff_speed = ctrl[CTRL_SPEED]; // RQ7
         next_eff_duplex = ctrl[CTRL_DUPLEX]; // RQ11
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         ctrl <= ctrl_reset_image(i_aneg_speed_100,
            i_aneg_full_duplex); // RQ8
         restart <= 1'b0;
         aneg_done <= 1'b0;
         neg_speed <= i_aneg_speed_100; // RQ13
         neg_duplex <= i_aneg_full_duplex; // RQ13
         eff_speed <= i_aneg_speed_100;
         eff_duplex <= i_aneg_full_duplex;
         ack <= 1'b0;
         idx_ok <= 1'b0;
         rdata <= '0;
      end else begin
         ctrl <= next_ctrl;
         restart <= next_restart;
         aneg_done <= next_aneg_done;
         neg_speed <= next_neg_speed;
         neg_duplex <= next_neg_duplex;
         eff_speed <= next_eff_speed;
         eff_duplex <= next_eff_duplex;
         ack <= next_ack;
         idx_ok <= next_idx_ok;
         rdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign o_mgmt_ack = ack;
   assign o_index_valid = idx_ok;
   assign o_mgmt_rdata = rdata;
   assign o_soft_reset = srst_busy;
   assign o_loopback = ctrl[CTRL_LOOPBACK]; // RQ6
   assign o_speed_100 = eff_speed;
   assign o_full_duplex = eff_duplex;
   assign o_aneg_enable = ctrl[CTRL_ANEG_EN]; // RQ8
   assign o_aneg_restart = restart;
   assign o_power_down = ctrl[CTRL_POWER_DOWN]; // RQ9
   assign o_col_test = ctrl[CTRL_COL_TEST]; // RQ12
   assign o_aneg_complete = aneg_done;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   localparam int AST_SRST_MAX = SRST_CYCLES + 1;

   logic ctrl_read_q;

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         ctrl_read_q <= 1'b0;
      end else begin
         ctrl_read_q <= i_mgmt_req && !i_mgmt_write &&
            (i_mgmt_index == IDX_BASIC_CTRL);
      end
   end

   AST_SRST_START: assert property (@(posedge i_sys_clk) // RQ4
      disable iff (i_reset) srst_start |=> o_soft_reset)
      else $error("soft reset did not start");

   AST_SRST_CLEARS: assert property (@(posedge i_sys_clk) // RQ4
      disable iff (i_reset)
      srst_start |=> ##[1:AST_SRST_MAX] !o_soft_reset)
      else $error("soft reset bit did not clear");

   AST_EXEMPT_KEPT: assert property (@(posedge i_sys_clk) // RQ3
      disable iff (i_reset) srst_busy |=>
      ((ctrl & SOFT_RESET_EXEMPT) == ($past(ctrl) & SOFT_RESET_EXEMPT)))
      else $error("exempt field changed by soft reset");

   AST_LOOPBACK: assert property (@(posedge i_sys_clk) // RQ6
      disable iff (i_reset) ctrl_wr && !srst_start |=>
      o_loopback == $past(i_mgmt_wdata[CTRL_LOOPBACK]))
      else $error("loopback does not follow write");

   AST_MANUAL_MODE: assert property (@(posedge i_sys_clk) // RQ7
      disable iff (i_reset) !ctrl[CTRL_ANEG_EN] |=>
      (o_speed_100 == $past(ctrl[CTRL_SPEED])) &&
      (o_full_duplex == $past(ctrl[CTRL_DUPLEX])))
      else $error("manual speed or duplex not applied");

   AST_ANEG_OVERRIDE: assert property (@(posedge i_sys_clk) // RQ11
      disable iff (i_reset) ctrl[CTRL_ANEG_EN] |=>
      (o_speed_100 == $past(neg_speed)) &&
      (o_full_duplex == $past(neg_duplex)))
      else $error("negotiated mode not applied");

   AST_RESTART_PULSE: assert property (@(posedge i_sys_clk) // RQ10
      disable iff (i_reset) o_aneg_restart && !ctrl_wr |=> !o_aneg_restart)
      else $error("restart bit did not self-clear");

   AST_DONE_SET: assert property (@(posedge i_sys_clk) // RQ14
      disable iff (i_reset) aneg_set |=> o_aneg_complete)
      else $error("completion flag not set");

   AST_PD_CLEARS_DONE: assert property (@(posedge i_sys_clk) // RQ9
      disable iff (i_reset) o_power_down |=> !o_aneg_complete)
      else $error("completion shown while powered down");

   AST_RESERVED_ZERO: assert property (@(posedge i_sys_clk) // RQ15
      disable iff (i_reset) o_mgmt_ack && ctrl_read_q |->
      ((o_mgmt_rdata & CTRL_RSVD_MASK) == 16'h0000))
      else $error("reserved control bits not zero");

   AST_UNMAPPED: assert property (@(posedge i_sys_clk) // RQ2
      disable iff (i_reset) i_mgmt_req && !index_mapped(i_mgmt_index)
      |=> o_mgmt_ack && !o_index_valid)
      else $error("unmapped index accepted");

   COV_SRST: cover property (@(posedge i_sys_clk)
      disable iff (i_reset) srst_start ##1 o_soft_reset);

   COV_RESTART_DONE: cover property (@(posedge i_sys_clk)
      disable iff (i_reset) o_aneg_restart ##[1:20] o_aneg_complete);

   COV_PD_EXIT: cover property (@(posedge i_sys_clk)
      disable iff (i_reset) $fell(o_power_down) ##[1:20] o_aneg_complete);

endmodule

/* src/phy_regs_pkg.sv */
// Contract
// [RQ1] PHY registers are not memory mapped; each is reached by index only.
// [RQ2] Indices 0-6, 17, 18, 27, 29, 30 and 31 decode; all others do not.
// [RQ3] Fields exempt from soft reset keep their value only on bit-15 reset.
// [RQ4] Writing 1 to control bit 15 starts a soft reset that self-clears.
// [RQ5] Software should set the reset bit alone, other bits left at zero.
// [RQ6] Control bit 14 selects loopback when 1, normal when 0, reset 0.
// [RQ7] Control bit 13 selects 100 or 10 Mbps, ignored under negotiation.
// [RQ8] Control bit 12 enables negotiation, resets to 1, overrides 13 and 8.
// [RQ9] Control bit 11 powers down; after clearing, completion sets status 5.
// [RQ10] Writing 1 to control bit 9 restarts negotiation and self-clears.
// [RQ11] Control bit 8 selects full or half duplex, ignored under negotiation.
// [RQ12] Control bit 7 enables the collision test, reset 0.
// [RQ13] Speed and duplex reset values come from the negotiation outcome.
// [RQ14] Status bit 5 is read-only and shows negotiation completed.
// [RQ15] Control bits 10 and 6-0 read as zero and ignore writes.
package phy_regs_pkg;

   localparam int CLK_PERIOD_NS = 100;
   localparam int SRST_TIME_NS = 500;
   localparam int SRST_CYCLES =
      (SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int IDX_W = 5;
   localparam int REG_W = 16;

   localparam logic [4:0] IDX_BASIC_CTRL = 5'h00;
   localparam logic [4:0] IDX_BASIC_STAT = 5'h01;
   localparam logic [4:0] IDX_ID_HI = 5'h02;
   localparam logic [4:0] IDX_ID_LO = 5'h03;
   localparam logic [4:0] IDX_ANEG_ADV = 5'h04;
   localparam logic [4:0] IDX_ANEG_PARTNER = 5'h05;
   localparam logic [4:0] IDX_ANEG_EXP = 5'h06;
   localparam logic [4:0] IDX_MODE_CTRL = 5'h11;
   localparam logic [4:0] IDX_SPECIAL_MODES = 5'h12;
   localparam logic [4:0] IDX_SPECIAL_IND = 5'h1b;
   localparam logic [4:0] IDX_INT_SOURCE = 5'h1d;
   localparam logic [4:0] IDX_INT_MASK = 5'h1e;
   localparam logic [4:0] IDX_SPECIAL_CTRL = 5'h1f;

   localparam int CTRL_RESET = 15;
   localparam int CTRL_LOOPBACK = 14;
   localparam int CTRL_SPEED = 13;
   localparam int CTRL_ANEG_EN = 12;
   localparam int CTRL_POWER_DOWN = 11;
   localparam int CTRL_RESTART = 9;
   localparam int CTRL_DUPLEX = 8;
   localparam int CTRL_COL_TEST = 7;
   localparam int STAT_ANEG_DONE = 5;

   localparam logic [15:0] CTRL_STORE_MASK = 16'h7980;
   localparam logic [15:0] CTRL_RESET_VAL = 16'h1000;
   localparam logic [15:0] CTRL_RSVD_MASK = 16'h047f;
   localparam logic [15:0] STAT_FIXED = 16'h7809;
   localparam logic [15:0] EXEMPT_NONE = 16'h0000;

   typedef enum logic {SRST_IDLE, SRST_HOLD} srst_state_t;

endpackage

/* src/phy_soft_reset_seq.sv */
`timescale 1ns/1ps
module phy_soft_reset_seq
   import phy_regs_pkg::*;
#(
   parameter int CYCLES = SRST_CYCLES
) (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_start,
   output logic o_busy
);

   localparam int CNT_W = $clog2(CYCLES + 1);
   localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

   srst_state_t state;
   srst_state_t next_state;
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] next_count;

   always_comb begin
      next_state = state;
      next_count = count;
      case (state)
         SRST_IDLE: begin
            next_count = '0;
            if (i_start) begin
               next_state = SRST_HOLD;
            end
         end
         SRST_HOLD: begin
            if (count == LAST) begin
               next_state = SRST_IDLE;
               next_count = '0;
            end else begin
               next_count = count + 1'b1;
            end
         end
         default: begin
            next_state = SRST_IDLE;
            next_count = '0;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         state <= SRST_IDLE;
         count <= '0;
      end else begin
         state <= next_state;
         count <= next_count;
      end
   end

   assign o_busy = (state == SRST_HOLD);

endmodule

/* tb/mgmt_host_model.sv */
`timescale 1ns/1ps
module mgmt_host_model (
   input wire logic i_sys_clk,
   input wire logic i_mgmt_ack,
   input wire logic [15:0] i_mgmt_rdata,
   output logic o_mgmt_req,
   output logic o_mgmt_write,
   output logic [4:0] o_mgmt_index,
   output logic [15:0] o_mgmt_wdata
);
   initial begin
      o_mgmt_req = 1'b0;
      o_mgmt_write = 1'b0;
      o_mgmt_index = 5'h00;
      o_mgmt_wdata = 16'h0000;
   end

   // One register access, selected by index only
   task automatic access(input logic wr, input logic [4:0] idx,
         input logic [15:0] wd, output logic [15:0] rd, output logic got);
      int n;
      got = 1'b0;
      rd = 16'h0000;
      @(posedge i_sys_clk);
      o_mgmt_req <= 1'b1;
      o_mgmt_write <= wr;
      o_mgmt_index <= idx;
      o_mgmt_wdata <= wd;
      @(posedge i_sys_clk);
      o_mgmt_req <= 1'b0;
      o_mgmt_write <= 1'b0;
      // Released data is no longer valid
      o_mgmt_wdata <= ~wd;
      for (n = 0; n < 4 && !got; n++) begin
         #1;
         if (i_mgmt_ack === 1'b1) begin
            got = 1'b1;
            rd = i_mgmt_rdata;
         end else begin
            @(posedge i_sys_clk);
         end
      end
   endtask
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
   import phy_regs_pkg::*;
   logic i_sys_clk, i_reset, i_mgmt_req, i_mgmt_write, i_aneg_done;
   logic i_aneg_speed_100, i_aneg_full_duplex;
   logic [4:0] i_mgmt_index;
   logic [15:0] i_mgmt_wdata, o_mgmt_rdata, rd, wv;
   logic o_mgmt_ack, o_index_valid, o_soft_reset, o_loopback, o_speed_100;
   logic o_full_duplex, o_aneg_enable, o_aneg_restart, o_power_down;
   logic o_col_test, o_aneg_complete;
   int mismatches, n_tests, seed, ctrl_m, restarts, srst_cnt, i, n, r;
   bit neg_spd, neg_dup, cmpl;

   localparam logic [15:0] KEEP = 16'h4000;

   phy_basic_control_regs #(
      .SOFT_RESET_EXEMPT(KEEP)
   ) phy_basic_control_regs_i (.*);
   mgmt_host_model mgmt_host_model_i (.i_sys_clk(i_sys_clk),
      .i_mgmt_ack(o_mgmt_ack), .i_mgmt_rdata(o_mgmt_rdata),
      .o_mgmt_req(i_mgmt_req), .o_mgmt_write(i_mgmt_write),
      .o_mgmt_index(i_mgmt_index), .o_mgmt_wdata(i_mgmt_wdata));

   initial begin
      i_sys_clk = 1'b0;
      forever #50 i_sys_clk = ~i_sys_clk;
   end

   always @(posedge i_sys_clk) begin
      if (o_aneg_restart === 1'b1) restarts++;
      if (o_soft_reset === 1'b1) srst_cnt++;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp,
         input string what);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp, input string what);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL %0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask

   task automatic xfer(input logic wr, input logic [4:0] idx,
         input logic [15:0] wd);
      logic got;
      mgmt_host_model_i.access(wr, idx, wd, rd, got);
      chk1(got, 1'b1, "ack");
   endtask

   task automatic do_reset(input int cycles);
      @(posedge i_sys_clk);
      r = $random(seed);
      i_aneg_speed_100 <= r[0];
      i_aneg_full_duplex <= r[1];
      i_reset <= 1'b1;
      repeat (cycles) @(posedge i_sys_clk);
      i_reset <= 1'b0;
      neg_spd = r[0];
      neg_dup = r[1];
      cmpl = 1'b0;
      ctrl_m = 32'h1000 | (neg_spd << 13) | (neg_dup << 8);
   endtask

   task automatic pulse_done(input bit spd, input bit dup);
      @(posedge i_sys_clk);
      i_aneg_speed_100 <= spd;
      i_aneg_full_duplex <= dup;
      i_aneg_done <= 1'b1;
      @(posedge i_sys_clk);
      i_aneg_done <= 1'b0;
   endtask

   task automatic chk_regs();
      xfer(1'b0, IDX_BASIC_CTRL, 16'h0000);
      chk(rd, ctrl_m[15:0], "control");
      xfer(1'b0, IDX_BASIC_STAT, 16'h0000);
      chk(rd, 16'h7809 | {10'h0, cmpl, 5'h0}, "status");
      chk1(o_loopback, ctrl_m[14], "loopback");
      chk1(o_speed_100, ctrl_m[12] ? neg_spd : ctrl_m[13], "speed");
      chk1(o_full_duplex, ctrl_m[12] ? neg_dup : ctrl_m[8], "duplex");
      chk1(o_aneg_enable, ctrl_m[12], "aneg enable");
      chk1(o_power_down, ctrl_m[11], "power down");
      chk1(o_col_test, ctrl_m[7], "col test");
      chk1(o_aneg_complete, cmpl, "complete");
      chk1(o_soft_reset, 1'b0, "soft reset");
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      #(100 * 5000);
      mismatches++;
      report_and_stop();
   end

   initial begin
      seed = 54454;
      i_reset = 1'b1;
      i_aneg_done = 1'b0;
      i_aneg_speed_100 = 1'b0;
      i_aneg_full_duplex = 1'b0;
      do_reset(8);
      chk_regs();
      $display("test reset values done");
      for (i = 0; i < 32; i++) begin
         xfer(1'b0, i[4:0], 16'h0000);
         chk1(o_index_valid, i <= 6 || i == 17 || i == 18 || i == 27 ||
            i >= 29, "decode");
         if (i > 1) chk(rd, 16'h0000, "other index");
      end
      $display("test index decode done");
      xfer(1'b1, IDX_ANEG_ADV, 16'hffff);
      for (i = 0; i < 12; i++) begin
         r = $random(seed);
         wv = r[15:0] & 16'h7fff;
         n = restarts;
         xfer(1'b1, IDX_BASIC_CTRL, wv);
         ctrl_m = wv & 16'h7980;
         cmpl = 1'b0;
         chk_regs();
         chk(16'(restarts - n), {15'h0, wv[9]}, "restart pulse");
      end
      $display("test control writes done");
      for (i = 0; i < 4; i++) begin
         wv = (i == 1) ? 16'h1800 : ((i == 3) ? 16'h1200 : 16'h1000);
         xfer(1'b1, IDX_BASIC_CTRL, wv);
         ctrl_m = wv & 16'h7980;
         cmpl = 1'b0;
         chk_regs();
         r = $random(seed);
         pulse_done(r[0], r[1]);
         if (i != 1) begin
            cmpl = 1'b1;
            neg_spd = r[0];
            neg_dup = r[1];
         end
         chk_regs();
      end
      $display("test negotiation done");
      xfer(1'b1, IDX_BASIC_CTRL, 16'h4980);
      srst_cnt = 0;
      xfer(1'b1, IDX_BASIC_CTRL, 16'h8000);
      chk1(o_soft_reset, 1'b1, "soft reset start");
      xfer(1'b1, IDX_BASIC_CTRL, 16'h4000);
      n = 0;
      while (o_soft_reset !== 1'b0 && n < 20) begin
         @(posedge i_sys_clk);
         #1;
         n++;
      end
      chk(16'(srst_cnt), 16'(SRST_CYCLES), "soft reset length");
      ctrl_m = 32'h1000 | (neg_spd << 13) | (neg_dup << 8) |
         (KEEP & 16'h4980);
      cmpl = 1'b0;
      chk_regs();
      $display("test soft reset done");
      xfer(1'b1, IDX_BASIC_CTRL, 16'h4100);
      do_reset(3);
      chk_regs();
      $display("test second reset done");
      report_and_stop();
   end
endmodule
